//--- verilog/mft_params.svh
`ifndef MFT_PARAMS_SVH
`define MFT_PARAMS_SVH
// register indexes, byte address is four times the index
`define IDX_CL0_HI   8'hf0
`define IDX_CL0_LO   8'hf1
`define IDX_CL1_HI   8'hf2
`define IDX_CL1_LO   8'hf3
`define IDX_CMP0_HI  8'hf4
`define IDX_CMP0_LO  8'hf5
`define IDX_CMP1_HI  8'hf6
`define IDX_CMP1_LO  8'hf7
`define IDX_TCR      8'hf8
`define IDX_TMR      8'hf9
`define IDX_DCFG     8'hfa
`define IDX_DSTAT    8'hfb
`define IDX_DMA_COUNTER_POINTER     8'hfc
`define IDX_DMA_ADDRESS_POINTER     8'hfd
`define IDX_CNT_HI   8'hfe
`define IDX_CNT_LO   8'hff
// timer_counter_control fields
`define TCR_CEN      7
`define TCR_CCP      6
`define TCR_CCMP     5
`define TCR_CCL      4
`define TCR_UDC      3
`define TCR_DIRECTION_STATUS     2
`define TCR_OF0      1
`define TCR_CS       0
// timer_mode_select fields
`define TMR_OEB      7
`define TMR_OEA      6
`define TMR_BM       5
`define TMR_RM1      4
`define TMR_RM0      3
`define TMR_ECK      2
`define TMR_REN      1
`define TMR_C0       0
// dma_config_reg fields
`define DCFG_SWAP_ENABLE    0
`define DCFG_CM0D    1
`define DCFG_CP0D    2
`define DCFG_GLOBAL_COUNTER_RUN    3
`define DCFG_PRIO_LO 4
`define DCFG_PRIO_HI 6
// dma status fields
`define DST_EOB_CMP  0
`define DST_EOB_CAP  1
`define DST_OUF      2
// reset values, top dma priority and counter maximum
`define RST_BYTE     8'h00
`define RST_WORD     16'h0000
`define RST_DCFG     8'h08
`define PRESC_RELOAD 8'h00
`define DMA_TOP_PRIO 3'h0
`define CNT_MAX      16'hffff
`endif

//--- verilog/mft_pkg.sv
package mft_pkg;
  typedef enum logic [2:0] {
    DMA_IDLE = 3'b001,
    DMA_HI   = 3'b010,
    DMA_LO   = 3'b100
  } dma_state_t;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
endpackage : mft_pkg

//--- verilog/multifunction_timer_dma_ctrl.sv
`timescale 1ns/1ps
`include "mft_params.svh"
module multifunction_timer_dma_ctrl (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [11:0]    paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic           timer_input_a,
  input  wire logic           timer_input_b,
  input  wire logic           dir_pin_fixed,
  input  wire logic           dir_pin_up,
  output logic                dma_req,
  output logic      [2:0]     dma_prio,
  output logic                dma_chan_cmp,
  output logic                dma_high_byte,
  input  wire logic           dma_ack,
  input  wire logic           dma_count_out,
  input  wire mft_pkg::byte_t dma_wdata,
  output mft_pkg::byte_t      dma_rdata,
  output mft_pkg::byte_t      dma_cnt_ptr,
  output mft_pkg::byte_t      dma_addr_ptr,
  output logic                dma_count_reset,
  output logic      [1:0]     eob_irq,
  output logic                ouf_irq,
  output logic                timer_output_a,
  output logic                timer_output_b
);
  import mft_pkg::*;

  function automatic logic at(input logic [11:0] a, input logic [7:0] idx);
    return a == {2'b00, idx, 2'b00};
  endfunction : at

  function automatic byte_t bsel(input word_t w, input logic hi);
    return hi ? w[15:8] : w[7:0];
  endfunction : bsel

  //////////////////////////////////////////////////////////////////////////////
  word_t      cl0_r, cl1_r, cmp0_r, cmp1_r, cnt_r;
  byte_t      tmr_r, dcfg_r, dma_counter_pointer_r, dma_address_pointer_r, psc_r, rd_r, dma_rdata_r;
  logic       cen_r, ccp_r, ccmp_r, udc_r, of0_r, stop_r, bisel_r;
  logic       out_a_r, out_b_r, ouf_r, dma_ch_r, blk_r;
  logic [1:0] eob_r, req_r;
  dma_state_t dma_st_r, dma_st_nxt;

  wire wr_en   = psel & penable & pwrite;
  wire setup   = psel & ~penable;
  wire mapped  = (paddr[11:10] == 2'b00) && (paddr[9:6] == 4'hf) && (paddr[1:0] == 2'b00);
  wire [7:0] wd = pwdata[7:0];
  wire w_cl0h  = wr_en & at(paddr, `IDX_CL0_HI);
  wire w_cl0l  = wr_en & at(paddr, `IDX_CL0_LO);
  wire w_cl1h  = wr_en & at(paddr, `IDX_CL1_HI);
  wire w_cl1l  = wr_en & at(paddr, `IDX_CL1_LO);
  wire w_cm0h  = wr_en & at(paddr, `IDX_CMP0_HI);
  wire w_cm0l  = wr_en & at(paddr, `IDX_CMP0_LO);
  wire w_cm1h  = wr_en & at(paddr, `IDX_CMP1_HI);
  wire w_cm1l  = wr_en & at(paddr, `IDX_CMP1_LO);
  wire w_tcr   = wr_en & at(paddr, `IDX_TCR);
  wire w_tmr   = wr_en & at(paddr, `IDX_TMR);
  wire w_dcfg  = wr_en & at(paddr, `IDX_DCFG);
  wire w_dst   = wr_en & at(paddr, `IDX_DSTAT);
  wire w_dma_counter_pointer  = wr_en & at(paddr, `IDX_DMA_COUNTER_POINTER);
  wire w_dma_address_pointer  = wr_en & at(paddr, `IDX_DMA_ADDRESS_POINTER);

  //////////////////////////////////////////////////////////////////////////////
  // counter control
  wire bm      = tmr_r[`TMR_BM];
  wire rm0     = tmr_r[`TMR_RM0];
  wire rm1     = tmr_r[`TMR_RM1];
  wire running = cen_r & dcfg_r[`DCFG_GLOBAL_COUNTER_RUN] & ~stop_r;
  wire tick    = running & (psc_r == 8'h00);
  wire dir_up  = dir_pin_fixed ? dir_pin_up : udc_r;
  wire over_under_flow     = tick & (dir_up ? (cnt_r == `CNT_MAX) : (cnt_r == `RST_WORD));
  wire cmp0_hit = tick & (cnt_r == cmp0_r);
  wire cmp1_hit = tick & (cnt_r == cmp1_r);
  // reg0 captures when its mode bit is set; reg1 mode ignored in bivalue
  wire cap1_mode = bm ? rm0 : rm1;
  wire monitor1  = ~bm & ~rm1;
  // load triggers ignored while running when the REN bit is set; captures always act
  wire retrig_ok = ~tmr_r[`TMR_REN] | ~running;
  // triggers act regardless of the enable
  wire cap0_ev  = timer_input_a & rm0;
  wire load0_ev = timer_input_a & ~rm0 & retrig_ok;
  wire cap1_ev  = timer_input_b & cap1_mode;
  wire ccl_wr   = w_tcr & wd[`TCR_CCL];
  wire clr_cnt  = ccl_wr | (ccp_r & (cap0_ev | cap1_ev)) | (ccmp_r & cmp0_hit);
  wire psc_load = clr_cnt | load0_ev;
  // biload alternates reload source on each wrap
  wire word_t reload_val = (bm & ~rm0 & bisel_r) ? cl1_r : cl0_r;
  wire one_shot = tmr_r[`TMR_C0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= `RST_WORD;
      psc_r   <= `PRESC_RELOAD;
      stop_r  <= 1'b0;
      bisel_r <= 1'b0;
    end else begin
      if (psc_load || (running && psc_r == 8'h00))
        psc_r <= `PRESC_RELOAD;
      else if (running)
        psc_r <= psc_r - 8'h01;
      if (clr_cnt)
        cnt_r <= `RST_WORD;
      else if (load0_ev)
        cnt_r <= cl0_r;
      // continuous reloads in load mode, one shot halts
      else if (over_under_flow && !rm0)
        cnt_r <= reload_val;
      else if (tick)
        cnt_r <= dir_up ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
      if (load0_ev || (w_tcr && wd[`TCR_CEN]))
        stop_r <= 1'b0;
      else if (over_under_flow && one_shot)
        stop_r <= 1'b1;
      if (over_under_flow)
        bisel_r <= ~bisel_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // dma sequencer
  wire cp_go   = req_r[1] & dcfg_r[`DCFG_CP0D];
  wire cm_go   = req_r[0] & dcfg_r[`DCFG_CM0D];
  wire st_idle = dma_st_r == DMA_IDLE;
  wire start   = st_idle & (cp_go | cm_go);
  wire byte_lo_done = (dma_st_r == DMA_LO) & dma_ack;
  wire eob_hw  = byte_lo_done & dma_count_out;
  wire [1:0] eob_set = eob_hw ? (dma_ch_r ? 2'b01 : 2'b10) : 2'b00;
  wire swap_enable    = dcfg_r[`DCFG_SWAP_ENABLE];

  // two byte transfers back to back
  always_comb begin
    dma_st_nxt = dma_st_r;
    case (dma_st_r)
      DMA_IDLE: begin
        if (cp_go | cm_go)
          dma_st_nxt = DMA_HI;
      end
      DMA_HI: begin
        if (dma_ack)
          dma_st_nxt = DMA_LO;
      end
      DMA_LO: begin
        if (dma_ack)
          dma_st_nxt = DMA_IDLE;
      end
      default: dma_st_nxt = DMA_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_st_r    <= DMA_IDLE;
      dma_ch_r    <= 1'b0;
      req_r       <= 2'b00;
      blk_r       <= 1'b0;
      dma_rdata_r <= `RST_BYTE;
    end else begin
      dma_st_r <= dma_st_nxt;
      // capture wins only when idle; in-service channel never preempted
      if (start)
        dma_ch_r <= ~cp_go;
      req_r[0] <= cmp0_hit | (req_r[0] & ~(start & ~cp_go));
      req_r[1] <= cap0_ev | (req_r[1] & ~(start & cp_go));
      // tells the dma side to reset its transaction counter
      blk_r <= eob_hw;
      dma_rdata_r <= bsel(cl0_r, dma_st_nxt == DMA_HI);
    end
  end

  assign dma_req       = ~st_idle;
  // top level for the second byte only
  assign dma_prio      = (dma_st_r == DMA_LO) ? `DMA_TOP_PRIO : dcfg_r[`DCFG_PRIO_HI:`DCFG_PRIO_LO];
  assign dma_chan_cmp  = dma_ch_r;
  assign dma_high_byte = dma_st_r == DMA_HI;
  assign dma_rdata     = dma_rdata_r;
  assign dma_count_reset = blk_r;
  // own toggle bit per channel, bit 1 picks the channel
  wire tgl = dma_ch_r ? dma_counter_pointer_r[2] : dma_address_pointer_r[2];
  assign dma_cnt_ptr  = {dma_counter_pointer_r[7:3], tgl, dma_ch_r, ~dma_high_byte};
  assign dma_addr_ptr = {dma_address_pointer_r[7:3], tgl, dma_ch_r, ~dma_high_byte};

  //////////////////////////////////////////////////////////////////////////////
  // data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cl0_r  <= `RST_WORD;
      cl1_r  <= `RST_WORD;
      cmp0_r <= `RST_WORD;
      cmp1_r <= `RST_WORD;
      of0_r  <= 1'b0;
    end else begin
      // high and low bytes reach the word separately
      if (cap0_ev)
        cl0_r <= cnt_r;
      else if (w_cl0h)
        cl0_r[15:8] <= wd;
      else if (w_cl0l)
        cl0_r[7:0] <= wd;
      if (cap1_ev || monitor1)
        cl1_r <= cnt_r;
      else if (w_cl1h)
        cl1_r[15:8] <= wd;
      else if (w_cl1l)
        cl1_r[7:0] <= wd;
      if (dma_ack && dma_ch_r && dma_st_r == DMA_HI)
        cmp0_r[15:8] <= dma_wdata;
      else if (byte_lo_done && dma_ch_r)
        cmp0_r[7:0] <= dma_wdata;
      else if (w_cm0h)
        cmp0_r[15:8] <= wd;
      else if (w_cm0l)
        cmp0_r[7:0] <= wd;
      if (w_cm1h)
        cmp1_r[15:8] <= wd;
      else if (w_cm1l)
        cmp1_r[7:0] <= wd;
      // wrap seen at a reg0 capture
      if (cap0_ev)
        of0_r <= over_under_flow;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control and dma registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cen_r   <= 1'b0;
      ccp_r   <= 1'b0;
      ccmp_r  <= 1'b0;
      udc_r   <= 1'b0;
      tmr_r   <= `RST_BYTE;
      dcfg_r  <= `RST_DCFG;
      dma_counter_pointer_r  <= `RST_BYTE;
      dma_address_pointer_r  <= `RST_BYTE;
      eob_r   <= 2'b00;
      ouf_r   <= 1'b0;
    end else begin
      if (w_tcr) begin
        cen_r  <= wd[`TCR_CEN];
        ccp_r  <= wd[`TCR_CCP];
        ccmp_r <= wd[`TCR_CCMP];
        udc_r  <= wd[`TCR_UDC];
      end
      // clock control only stored, parallel mode absent here
      if (w_tmr)
        tmr_r <= wd;
      // repeat end-of-block kills that channel's dma mask
      // mask re-enable is software's last step
      if (w_dcfg)
        dcfg_r <= wd;
      if (eob_set[0] && eob_r[0])
        dcfg_r[`DCFG_CM0D] <= 1'b0;
      if (eob_set[1] && eob_r[1])
        dcfg_r[`DCFG_CP0D] <= 1'b0;
      // one swap bit; toggle on this channel's end-of-block
      if (w_dma_counter_pointer)
        dma_counter_pointer_r <= wd;
      if (swap_enable && eob_set[0])
        dma_counter_pointer_r[2] <= ~(w_dma_counter_pointer ? wd[2] : dma_counter_pointer_r[2]);
      if (w_dma_address_pointer)
        dma_address_pointer_r <= wd;
      if (swap_enable && eob_set[1])
        dma_address_pointer_r[2] <= ~(w_dma_address_pointer ? wd[2] : dma_address_pointer_r[2]);
      // test write of 1 to an end-of-block bit counts only in swap mode; hardware set wins
      if (w_dst)
        eob_r <= eob_set | ({wd[`DST_EOB_CAP], wd[`DST_EOB_CMP]} & {2{swap_enable}});
      else
        eob_r <= eob_r | eob_set;
      if (over_under_flow)
        ouf_r <= 1'b1;
      else if (w_dst)
        ouf_r <= wd[`DST_OUF];
    end
  end

  // end-of-block yields to dma and wrap interrupt
  assign eob_irq = eob_r & {2{~dma_req & ~ouf_r}};
  assign ouf_irq = ouf_r;

  //////////////////////////////////////////////////////////////////////////////
  // outputs: wrap sets, compare resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
    end else begin
      if (over_under_flow)
        out_a_r <= 1'b1;
      else if (cmp0_hit)
        out_a_r <= 1'b0;
      if (over_under_flow)
        out_b_r <= 1'b1;
      else if (cmp1_hit)
        out_b_r <= 1'b0;
    end
  end

  assign timer_output_a = tmr_r[`TMR_OEA] ? out_a_r : 1'b1;
  assign timer_output_b = tmr_r[`TMR_OEB] ? out_b_r : 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // read path; data latched in setup so prdata is a flop
  wire byte_t tcr_rd = {cen_r, ccp_r, ccmp_r, 1'b0, udc_r, dir_up, of0_r, running};
  wire byte_t dst_rd = {5'h00, ouf_r, eob_r[1], eob_r[0]};
  byte_t rd_mux;
  always_comb begin
    case (paddr[5:2])
      4'h0: rd_mux = cl0_r[15:8];
      4'h1: rd_mux = cl0_r[7:0];
      4'h2: rd_mux = cl1_r[15:8];
      4'h3: rd_mux = cl1_r[7:0];
      4'h4: rd_mux = cmp0_r[15:8];
      4'h5: rd_mux = cmp0_r[7:0];
      4'h6: rd_mux = cmp1_r[15:8];
      4'h7: rd_mux = cmp1_r[7:0];
      4'h8: rd_mux = tcr_rd;
      4'h9: rd_mux = tmr_r;
      4'ha: rd_mux = dcfg_r;
      4'hb: rd_mux = dst_rd;
      4'hc: rd_mux = dma_counter_pointer_r;
      4'hd: rd_mux = dma_address_pointer_r;
      4'he: rd_mux = cnt_r[15:8];
      default: rd_mux = cnt_r[7:0];
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rd_r <= `RST_BYTE;
    else if (setup)
      rd_r <= mapped ? rd_mux : `RST_BYTE;
  end

  assign prdata  = {24'h000000, rd_r};
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
endmodule : multifunction_timer_dma_ctrl

//--- bench/mft_ctrl_properties.sv
`timescale 1ns/1ps
module mft_ctrl_checker (
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           dma_req,
  input wire logic [2:0]     dma_prio,
  input wire logic           dma_chan_cmp,
  input wire logic           dma_high_byte,
  input wire logic           dma_ack,
  input wire logic           dma_count_out,
  input wire mft_pkg::byte_t dma_cnt_ptr,
  input wire mft_pkg::byte_t dma_addr_ptr,
  input wire logic           dma_count_reset,
  input wire logic [1:0]     eob_irq,
  input wire logic           ouf_irq
);
  import mft_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  a_word_high_first: assert property (
    $rose(dma_req) |-> dma_high_byte) else $error("word did not open on high byte");
  a_high_to_low: assert property (
    dma_req && dma_high_byte && dma_ack |=> dma_req && !dma_high_byte) else $error("no low byte after high");
  a_low_ends_word: assert property (
    dma_req && !dma_high_byte && dma_ack |=> !dma_req) else $error("word not closed after low byte");
  a_low_top_prio: assert property (
    dma_req && !dma_high_byte |-> dma_prio == 3'h0) else $error("low byte not at top priority");
  a_chan_held: assert property (
    dma_req && $past(dma_req) |-> $stable(dma_chan_cmp)) else $error("channel changed within word");
  a_eob_count_reset: assert property (
    dma_req && !dma_high_byte && dma_ack && dma_count_out |=> dma_count_reset ##1 !dma_count_reset)
    else $error("count reset pulse missing");
  a_eob_irq_quiet: assert property (
    |eob_irq |-> !dma_req && !ouf_irq) else $error("end of block irq while dma or wrap active");
  a_ptr_channel: assert property (
    dma_req |-> dma_cnt_ptr[1] == dma_chan_cmp && dma_addr_ptr[1] == dma_chan_cmp)
    else $error("pointer channel bit wrong");
  a_ptr_byte: assert property (
    dma_req |-> dma_cnt_ptr[0] == !dma_high_byte) else $error("pointer byte bit wrong");
endmodule : mft_ctrl_checker

//--- bench/dma_host_model.sv
`timescale 1ns/1ps
module dma_host_model (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           dma_req,
  input  wire logic           dma_high_byte,
  input  wire mft_pkg::byte_t dma_rdata,
  input  wire logic [1:0]     delay,
  input  wire logic           last_out,
  input  wire mft_pkg::word_t wword,
  output logic                dma_ack,
  output logic                dma_count_out,
  output mft_pkg::byte_t      dma_wdata,
  output mft_pkg::word_t      got_word
);
  import mft_pkg::*;
  logic [1:0] wait_r;
  ////////////////////////////////////////////////////////////////
  // one ack per byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_ack <= 1'b0;
      wait_r  <= 2'h0;
    end else if (dma_ack || !dma_req) begin
      dma_ack <= 1'b0;
      wait_r  <= 2'h0;
    end else if (wait_r >= delay) begin
      dma_ack <= 1'b1;
      if (dma_high_byte) got_word[15:8] <= dma_rdata;
      else got_word[7:0] <= dma_rdata;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
  assign dma_count_out = last_out & dma_req & !dma_high_byte;
  // idle bus shows junk, not the last byte
  assign dma_wdata = !dma_req ? ~wword[7:0] : (dma_high_byte ? wword[15:8] : wword[7:0]);
endmodule : dma_host_model

//--- bench/tb_top.sv
`timescale 1ns/1ps
`include "mft_params.svh"
module tb_top;
  import mft_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        timer_input_a, timer_input_b, dir_pin_fixed, dir_pin_up, last_out;
  logic        dma_req, dma_chan_cmp, dma_high_byte, dma_ack, dma_count_out, dma_count_reset, ouf_irq;
  logic [2:0]  dma_prio;
  logic [1:0]  eob_irq, delay;
  logic        timer_output_a, timer_output_b;
  byte_t       dma_wdata, dma_rdata, dma_cnt_ptr, dma_addr_ptr, rv;
  word_t       wword, got_word, c1, c2;
  int          errors, comparisons, shadow[int];
  multifunction_timer_dma_ctrl u_multifunction_timer_dma_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_input_a(timer_input_a), .timer_input_b(timer_input_b),
    .dir_pin_fixed(dir_pin_fixed), .dir_pin_up(dir_pin_up), .dma_req(dma_req), .dma_prio(dma_prio),
    .dma_chan_cmp(dma_chan_cmp), .dma_high_byte(dma_high_byte), .dma_ack(dma_ack),
    .dma_count_out(dma_count_out), .dma_wdata(dma_wdata), .dma_rdata(dma_rdata), .dma_cnt_ptr(dma_cnt_ptr),
    .dma_addr_ptr(dma_addr_ptr), .dma_count_reset(dma_count_reset), .eob_irq(eob_irq), .ouf_irq(ouf_irq),
    .timer_output_a(timer_output_a), .timer_output_b(timer_output_b));
  dma_host_model u_dma_host_model (.pclk(pclk), .presetn(presetn), .dma_req(dma_req),
    .dma_high_byte(dma_high_byte), .dma_rdata(dma_rdata), .delay(delay), .last_out(last_out),
    .wword(wword), .dma_ack(dma_ack), .dma_count_out(dma_count_out), .dma_wdata(dma_wdata),
    .got_word(got_word));
  always #10 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input byte_t idx, input byte_t wd);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input byte_t idx, input byte_t wd);
    apb(1'b1, idx, wd);
  endtask : wr
  task automatic rdchk(input byte_t idx, input byte_t exp);
    apb(1'b0, idx, 8'h00);
    chk({24'h000000, rv}, {24'h000000, exp});
  endtask : rdchk
  task automatic rd_cnt(output word_t c);
    apb(1'b0, `IDX_CNT_HI, 8'h00);
    c[15:8] = rv;
    apb(1'b0, `IDX_CNT_LO, 8'h00);
    c[7:0] = rv;
  endtask : rd_cnt
  // pulse trigger a, then wait a bounded time for any word transfer
  task automatic capture_word(input logic expect_dma);
    logic seen;
    seen = 1'b0;
    delay <= 2'($urandom);
    timer_input_a <= 1'b1;
    @(posedge pclk);
    timer_input_a <= 1'b0;
    for (int n = 0; n < 40; n++) begin
      @(negedge pclk);
      seen |= dma_req;
      if (seen && !dma_req) break;
    end
    @(posedge pclk);
    chk(seen, expect_dma);
  endtask : capture_word
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
  initial begin
    {pclk, psel, penable, pwrite, timer_input_a, timer_input_b, dir_pin_fixed, dir_pin_up, last_out} = '0;
    {paddr, pwdata, delay, wword, errors, comparisons} = '0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    void'($urandom(60));
    for (int i = 4; i < 10; i++) rdchk(8'hf0 + 8'(i), 8'h00);
    rdchk(`IDX_DCFG, `RST_DCFG);
    for (int i = 0; i < 10; i++) if (i != 8) shadow[i] = $urandom % 256;
    // reg1 kept in capture mode, monitor mode would overwrite it every cycle
    shadow[9] = (shadow[9] | 32'h10) & 32'hdf;
    wr(`IDX_TMR, 8'h10);
    foreach (shadow[i]) wr(8'hf0 + 8'(i), 8'(shadow[i]));
    foreach (shadow[i]) rdchk(8'hf0 + 8'(i), 8'(shadow[i]));
    wr(`IDX_TMR, 8'h00);
    chk({timer_output_a, timer_output_b}, 2'b11);
    wr(`IDX_TMR, 8'hc0);
    chk({timer_output_a, timer_output_b}, 2'b00);
    apb(1'b0, 8'h00, 8'h00);
    chk({err, rv}, 9'h100);
    // counting up, then direction forced down by pins
    wr(`IDX_TCR, 8'h88);
    repeat (20) @(posedge pclk);
    rdchk(`IDX_TCR, 8'h8d);
    dir_pin_fixed <= 1'b1;
    @(posedge pclk);
    rdchk(`IDX_TCR, 8'h89);
    dir_pin_fixed <= 1'b0;
    wr(`IDX_DCFG, 8'h00);
    rdchk(`IDX_TCR, 8'h8c);
    rd_cnt(c1);
    repeat (5) @(posedge pclk);
    rd_cnt(c2);
    chk(c2, c1);
    wr(`IDX_TMR, 8'h08);
    capture_word(1'b0);
    rdchk(`IDX_CL0_HI, c1[15:8]);
    rdchk(`IDX_CL0_LO, c1[7:0]);
    rd_cnt(c2);
    chk(c2, c1);
    wr(`IDX_DCFG, 8'h08);
    repeat (30) @(posedge pclk);
    wr(`IDX_DCFG, 8'h35);
    rd_cnt(c1);
    wr(`IDX_TCR, 8'h98);
    rdchk(`IDX_TCR, 8'h8c);
    rd_cnt(c2);
    chk({ouf_irq, c2}, 17'h0);
    wr(`IDX_CL0_HI, 8'h00);
    // word dma of a captured value, swap on
    wr(`IDX_TCR, 8'hc8);
    wr(`IDX_DMA_ADDRESS_POINTER, 8'h40);
    wr(`IDX_DMA_COUNTER_POINTER, 8'h80);
    last_out <= 1'b1;
    capture_word(1'b1);
    chk(got_word, 16'h0000);
    rdchk(`IDX_DSTAT, 8'h02);
    rdchk(`IDX_DMA_ADDRESS_POINTER, 8'h44);
    rdchk(`IDX_DMA_COUNTER_POINTER, 8'h80);
    chk(eob_irq, 2'b10);
    capture_word(1'b1);
    rdchk(`IDX_DCFG, 8'h31);
    capture_word(1'b0);
    wr(`IDX_DMA_ADDRESS_POINTER, 8'h40);
    wr(`IDX_DSTAT, 8'h00);
    rdchk(`IDX_DCFG, 8'h31);
    // held capture request drains on re-enable, no runout this time
    last_out <= 1'b0;
    wr(`IDX_DCFG, 8'h35);
    repeat (20) @(posedge pclk);
    chk(eob_irq, 2'b00);
    wr(`IDX_DSTAT, 8'h01);
    chk(eob_irq, 2'b01);
    wr(`IDX_DSTAT, 8'h00);
    wr(`IDX_DCFG, 8'h34);
    wr(`IDX_DSTAT, 8'h01);
    rdchk(`IDX_DSTAT, 8'h00);
    last_out <= 1'b1;
    capture_word(1'b1);
    rdchk(`IDX_DMA_ADDRESS_POINTER, 8'h40);
    // compare channel: stale request drained first, then a forced match at 8
    last_out <= 1'b0;
    wr(`IDX_DCFG, 8'h02);
    repeat (20) @(posedge pclk);
    last_out <= 1'b1;
    wword    <= 16'($urandom) | 16'h8000;
    wr(`IDX_CMP0_HI, 8'h00);
    wr(`IDX_CMP0_LO, 8'h08);
    wr(`IDX_TCR, 8'h98);
    wr(`IDX_DCFG, 8'h0b);
    repeat (40) @(posedge pclk);
    wr(`IDX_DCFG, 8'h01);
    rdchk(`IDX_CMP0_HI, wword[15:8]);
    rdchk(`IDX_CMP0_LO, wword[7:0]);
    rdchk(`IDX_DSTAT, 8'h03);
    rdchk(`IDX_DMA_COUNTER_POINTER, 8'h84);
    rdchk(`IDX_DMA_ADDRESS_POINTER, 8'h40);
    end_of_test();
  end
endmodule : tb_top
bind multifunction_timer_dma_ctrl mft_ctrl_checker u_mft_ctrl_checker (.pclk(pclk), .presetn(presetn),
  .dma_req(dma_req), .dma_prio(dma_prio), .dma_chan_cmp(dma_chan_cmp), .dma_high_byte(dma_high_byte),
  .dma_ack(dma_ack), .dma_count_out(dma_count_out), .dma_cnt_ptr(dma_cnt_ptr), .dma_addr_ptr(dma_addr_ptr),
  .dma_count_reset(dma_count_reset), .eob_irq(eob_irq), .ouf_irq(ouf_irq));
